// ===== logic/dio_port_pkg.sv
package dio_port_pkg;

    // Register offsets on the plain register port (byte addresses)
    localparam logic [7:0] OFF_PORT_SELECT = 8'h00;
    localparam logic [7:0] OFF_PORT_CFG    = 8'h04;
    localparam logic [7:0] OFF_EXT_CFG     = 8'h08;
    localparam logic [7:0] OFF_SYNC_CFG    = 8'h0c;
    localparam logic [7:0] OFF_PULSE_LEN   = 8'h10;
    localparam logic [7:0] OFF_OUT_DATA    = 8'h14;
    localparam logic [7:0] OFF_IN_DATA     = 8'h18;
    localparam logic [7:0] OFF_EVENT_REQ   = 8'h1c;
    localparam logic [7:0] OFF_STAMP_BASE  = 8'h20;
    localparam logic [7:0] OFF_STAMP_LAST  = 8'h3c;

    // Reset values (EEPROM load replaces them)
    localparam logic [7:0]  RST_PORT_SELECT = 8'h04;
    localparam logic [15:0] RST_PORT_CFG    = 16'h0000;
    localparam logic [15:0] RST_EXT_CFG     = 16'h0000;
    localparam logic [7:0]  RST_SYNC_CFG    = 8'h00;
    localparam logic [15:0] RST_PULSE_LEN   = 16'h0001;

    // Port configuration fields
    localparam int PCFG_IN_SEL_LSB  = 0;
    localparam int PCFG_OUT_SEL_LSB = 2;
    localparam int PCFG_BIDIR       = 4;
    localparam int PCFG_WD_IMMED    = 5;
    localparam int PCFG_STB_WD_MAP  = 6;
    localparam int PCFG_STB_POL     = 7;

    // Time-event/edge-stamp configuration fields, one nibble per pin
    localparam int SCFG_SYNC_SEL = 0;
    localparam int SCFG_OPEN     = 1;
    localparam int SCFG_POL      = 2;
    localparam int SCFG_MAP      = 3;
    localparam int SCFG_STRIDE   = 4;

    // Event request fields
    localparam int EVR_KIND_LSB = 8;

    // Port-select codes
    localparam logic [7:0] CODE_DIO    = 8'h04;
    localparam logic [7:0] CODE_ALTSER = 8'h05;

    // Timing
    localparam int CLK_PERIOD_NS  = 5;
    localparam int STROBE_MIN_NS  = 75;
    localparam int WD_PULSE_MAX_NS = 45;
    localparam int STROBE_CYCLES  = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WD_PULSE_CYCLES = WD_PULSE_MAX_NS / CLK_PERIOD_NS;

    // Port kind, one-hot
    typedef enum logic [7:0] {
        KIND_NONE     = 8'h01,
        KIND_DIO      = 8'h02,
        KIND_ALTSER   = 8'h04,
        KIND_SERIAL   = 8'h08,
        KIND_HB8_LEG  = 8'h10,
        KIND_HB16_LEG = 8'h20,
        KIND_HB8_DIR  = 8'h40,
        KIND_HB16_DIR = 8'h80
    } port_kind_t;

    // Core events, one-cycle pulses
    typedef struct packed {
        logic frame_start;
        logic frame_end;
        logic frame_end_pdwd;
        logic wd_expired;
        logic wd_trigger;
        logic time_event_b;
        logic time_event_a;
    } core_events_t;

    // Register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } reg_req_t;

    // EEPROM load word
    typedef struct packed {
        logic        valid;
        logic [7:0]  addr;
        logic [15:0] data;
    } eeprom_load_t;

endpackage : dio_port_pkg

// ===== logic/digital_io_process_port_sync_latch.sv
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps

// Functional notes
// - Stamp both rising and falling edges of each edge-stamp input.
// - Each shared pin is time-event output or edge-stamp input per its bit.
// - Output mode picks push-pull or open drain/source, and polarity.
// - Enabled time-event output holds its input low unless remapped (b in I/O mode).
// - Map bit reflects time-event state into event request bits.
// - Time-event pulse width follows pulse-length register, EEPROM loaded.
// - Code 04h digital I/O, 05h alternate serial, 80h/82h serial.
// - 88h/8Ah/8Ch 8-bit, 89h/8Bh/8Dh 16-bit legacy host bus.
// - 90h/92h/94h 8-bit, 91h/93h/95h 16-bit direct host bus.
// - One config register pair, meaning depends on mode, EEPROM loaded.
// - Sixteen I/O lines, output data drives, input data returns samples.
// - Each adjacent line pair is set as a unit in or out.
// - Extended config bit n sets pair n direction; 1 means output.
// - Bidirectional mode drives outputs for latching then releases lines.
// - Watchdog bit resets outputs at once or at next update event.
// - Pulse watchdog output whenever the buffer watchdog is triggered.
// - Strobe mode bit also routes watchdog pulse onto output strobe.
// - Inputs sampled at frame start, strobe rise, event a or event b.
// - Outputs updated at frame end, event a, event b, or watchdog frame end.
// - Output strobe active level set by polarity bit.
module digital_io_process_port_sync_latch (
    input  wire logic                       clk_sys_in,
    input  wire logic                       arst_n_in,
    input  wire logic                       clk_en_in,
    input  wire dio_port_pkg::reg_req_t     reg_req_in,
    output logic [31:0]                     reg_rdata_out,
    input  wire dio_port_pkg::eeprom_load_t eeprom_load_in,
    input  wire dio_port_pkg::core_events_t core_events_in,
    input  wire logic [63:0]                system_time_in,
    input  wire logic                       shared_pin_a_in,
    output logic                            shared_pin_a_out,
    output logic                            shared_pin_a_oe_out,
    input  wire logic                       shared_pin_b_in,
    output logic                            shared_pin_b_out,
    output logic                            shared_pin_b_oe_out,
    input  wire logic                       edge_stamp_alt_b_in,
    input  wire logic                       sample_strobe_in,
    input  wire logic                       external_output_kill_in,
    input  wire logic [15:0]                digital_io_lines_in,
    output logic [15:0]                     digital_io_lines_out,
    output logic [15:0]                     digital_io_lines_oe_out,
    output logic                            output_strobe_out,
    output logic                            watchdog_pulse_out,
    output logic [1:0]                      event_req_state_out
);
    import dio_port_pkg::*;

    // Port-select decode
    function automatic port_kind_t decode_kind(input logic [7:0] code);
        port_kind_t k;
        k = KIND_NONE;
        if (code == CODE_DIO)                      k = KIND_DIO;
        else if (code == CODE_ALTSER)              k = KIND_ALTSER;
        else if (code == 8'h80 || code == 8'h82)   k = KIND_SERIAL;
        else if (code == 8'h88 || code == 8'h8a || code == 8'h8c) k = KIND_HB8_LEG;
        else if (code == 8'h89 || code == 8'h8b || code == 8'h8d) k = KIND_HB16_LEG;
        else if (code == 8'h90 || code == 8'h92 || code == 8'h94) k = KIND_HB8_DIR;
        else if (code == 8'h91 || code == 8'h93 || code == 8'h95) k = KIND_HB16_DIR;
        return k;
    endfunction : decode_kind

    // Shared pin drive {out, oe}
    function automatic logic [1:0] pin_drive(input logic sel, input logic act,
                                             input logic open, input logic pol);
        logic lvl;
        lvl = act ^ pol;
        if (!sel)      return 2'b00;
        else if (open) return {lvl, act};
        else           return {lvl, 1'b1};
    endfunction : pin_drive

    // Configuration registers
    logic [7:0]  port_sel_q;
    logic [15:0] port_cfg_q;
    logic [15:0] ext_cfg_q;
    logic [7:0]  sync_cfg_q;
    logic [15:0] pulse_len_q;
    logic [15:0] out_data_q;
    logic        fresh_q;

    // Datapath state
    logic [15:0] sync_cnt_q [2];
    logic [1:0]  latch_prev_q;
    logic        stamp_armed_q;
    logic [63:0] stamp_q [4];
    logic        strobe_prev_q;
    logic [15:0] in_data_q;
    logic [15:0] out_lines_q;
    logic        killed_q;
    logic        kill_pending_q;
    logic [4:0]  stb_cnt_q;
    logic [3:0]  wdp_cnt_q;

    // Config write path: EEPROM load or software write
    wire         cfg_we    = clk_en_in && (eeprom_load_in.valid || reg_req_in.wr);
    wire [7:0]   cfg_addr  = eeprom_load_in.valid ? eeprom_load_in.addr : reg_req_in.addr;
    wire [15:0]  cfg_wdata = eeprom_load_in.valid ? eeprom_load_in.data
                                                  : reg_req_in.wdata[15:0];

    // Mode decode and pin configuration
    port_kind_t kind;
    assign kind = decode_kind(port_sel_q);
    wire        is_dio    = (kind == KIND_DIO);
    wire [1:0]  sync_sel  = {sync_cfg_q[SCFG_STRIDE + SCFG_SYNC_SEL], sync_cfg_q[SCFG_SYNC_SEL]};
    wire [1:0]  sync_open = {sync_cfg_q[SCFG_STRIDE + SCFG_OPEN], sync_cfg_q[SCFG_OPEN]};
    wire [1:0]  sync_pol  = {sync_cfg_q[SCFG_STRIDE + SCFG_POL], sync_cfg_q[SCFG_POL]};
    wire [1:0]  sync_map  = {sync_cfg_q[SCFG_STRIDE + SCFG_MAP], sync_cfg_q[SCFG_MAP]};
    wire [1:0]  sync_start = {core_events_in.time_event_b, core_events_in.time_event_a};
    wire [15:0] pulse_eff = (pulse_len_q == 16'h0000) ? 16'h0001 : pulse_len_q;
    wire [1:0]  sync_act  = {sync_cnt_q[1] != 16'h0000, sync_cnt_q[0] != 16'h0000};
    wire [1:0]  drv_a     = pin_drive(sync_sel[0], sync_act[0], sync_open[0], sync_pol[0]);
    wire [1:0]  drv_b     = pin_drive(sync_sel[1], sync_act[1], sync_open[1], sync_pol[1]);

    // Edge-stamp sources: held low behind an enabled output, b remapped in I/O mode
    wire [1:0]  latch_raw = {sync_sel[1] ? (is_dio & edge_stamp_alt_b_in) : shared_pin_b_in,
                             sync_sel[0] ? 1'b0 : shared_pin_a_in};
    // No edge until one enabled cycle has loaded the real idle level after reset
    wire [1:0]  latch_rise = latch_raw & ~latch_prev_q & {2{stamp_armed_q}};
    wire [1:0]  latch_fall = ~latch_raw & latch_prev_q & {2{stamp_armed_q}};

    // Sample and update event selection
    wire [1:0]  in_sel  = port_cfg_q[PCFG_IN_SEL_LSB +: 2];
    wire [1:0]  out_sel = port_cfg_q[PCFG_OUT_SEL_LSB +: 2];
    wire        stb_rise = sample_strobe_in & ~strobe_prev_q;
    wire        in_ev = (in_sel == 2'd0) ? core_events_in.frame_start :
                        (in_sel == 2'd1) ? stb_rise :
                        (in_sel == 2'd2) ? core_events_in.time_event_a :
                                           core_events_in.time_event_b;
    wire        upd_ev = is_dio && ((out_sel == 2'd0) ? core_events_in.frame_end :
                                    (out_sel == 2'd1) ? core_events_in.time_event_a :
                                    (out_sel == 2'd2) ? core_events_in.time_event_b :
                                                        core_events_in.frame_end_pdwd);
    wire        wd_exp    = core_events_in.wd_expired;
    wire        wd_immed  = port_cfg_q[PCFG_WD_IMMED];
    wire        upd_zero  = kill_pending_q || (wd_exp && !wd_immed) || (killed_q && !fresh_q);
    wire        data_wr   = clk_en_in && reg_req_in.wr && reg_req_in.addr == OFF_OUT_DATA;

    // Line direction: pairs from extended config, or strobe window in bidirectional mode
    logic [15:0] dir_lines;
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            dir_lines[i] = ext_cfg_q[i / 2];
        end
    end
    wire         stb_act  = (stb_cnt_q != 5'd0);
    wire         wdp_act  = (wdp_cnt_q != 4'd0);
    wire [15:0]  oe_next  = !is_dio ? 16'h0000 :
                            port_cfg_q[PCFG_BIDIR] ? {16{stb_act}} : dir_lines;
    wire         stb_level = (stb_act || (port_cfg_q[PCFG_STB_WD_MAP] && wdp_act))
                             ^ port_cfg_q[PCFG_STB_POL];

    // Register read decode
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (reg_req_in.addr >= OFF_STAMP_BASE && reg_req_in.addr <= OFF_STAMP_LAST) begin
            rd_mux = reg_req_in.addr[2] ? stamp_q[reg_req_in.addr[4:3]][63:32]
                                        : stamp_q[reg_req_in.addr[4:3]][31:0];
        end else begin
            unique case (reg_req_in.addr)
                OFF_PORT_SELECT: rd_mux = {24'h0, port_sel_q};
                OFF_PORT_CFG:    rd_mux = {16'h0, port_cfg_q};
                OFF_EXT_CFG:     rd_mux = {16'h0, ext_cfg_q};
                OFF_SYNC_CFG:    rd_mux = {24'h0, sync_cfg_q};
                OFF_PULSE_LEN:   rd_mux = {16'h0, pulse_len_q};
                OFF_OUT_DATA:    rd_mux = {16'h0, out_data_q};
                OFF_IN_DATA:     rd_mux = {16'h0, in_data_q};
                OFF_EVENT_REQ:   rd_mux = {16'h0, kind, 6'h00, event_req_state_out};
                default:         rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // Configuration registers, one pair of port config shared by all modes
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            port_sel_q  <= RST_PORT_SELECT;
            port_cfg_q  <= RST_PORT_CFG;
            ext_cfg_q   <= RST_EXT_CFG;
            sync_cfg_q  <= RST_SYNC_CFG;
            pulse_len_q <= RST_PULSE_LEN;
        end else if (cfg_we) begin
            if (cfg_addr == OFF_PORT_SELECT) port_sel_q  <= cfg_wdata[7:0];
            if (cfg_addr == OFF_PORT_CFG)    port_cfg_q  <= cfg_wdata;
            if (cfg_addr == OFF_EXT_CFG)     ext_cfg_q   <= cfg_wdata;
            if (cfg_addr == OFF_SYNC_CFG)    sync_cfg_q  <= cfg_wdata[7:0];
            if (cfg_addr == OFF_PULSE_LEN)   pulse_len_q <= cfg_wdata;
        end
    end

    // Output data register and freshness since the last update event or watchdog expiry
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            out_data_q <= 16'h0000;
            fresh_q    <= 1'b0;
        end else if (clk_en_in) begin
            if (data_wr) out_data_q <= reg_req_in.wdata[15:0];
            if (data_wr) fresh_q <= 1'b1;
            else if (upd_ev || wd_exp) fresh_q <= 1'b0;
        end
    end

    // Time-event pulse counters
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync_cnt_q[0] <= 16'h0000;
            sync_cnt_q[1] <= 16'h0000;
        end else if (clk_en_in) begin
            for (int i = 0; i < 2; i++) begin
                if (sync_start[i]) sync_cnt_q[i] <= pulse_eff;
                else if (sync_act[i]) sync_cnt_q[i] <= sync_cnt_q[i] - 16'h0001;
            end
        end
    end

    // Shared pins and event request state
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            {shared_pin_a_out, shared_pin_a_oe_out} <= 2'b00;
            {shared_pin_b_out, shared_pin_b_oe_out} <= 2'b00;
            event_req_state_out <= 2'b00;
        end else if (clk_en_in) begin
            {shared_pin_a_out, shared_pin_a_oe_out} <= drv_a;
            {shared_pin_b_out, shared_pin_b_oe_out} <= drv_b;
            event_req_state_out <= sync_act & sync_map;
        end
    end

    // Edge time stamps, separate per input and edge
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            latch_prev_q <= 2'b00;
            stamp_armed_q <= 1'b0;
            for (int k = 0; k < 4; k++) stamp_q[k] <= 64'h0;
        end else if (clk_en_in) begin
            latch_prev_q <= latch_raw;
            stamp_armed_q <= 1'b1;
            for (int i = 0; i < 2; i++) begin
                if (latch_rise[i]) stamp_q[2 * i] <= system_time_in;
                if (latch_fall[i]) stamp_q[2 * i + 1] <= system_time_in;
            end
        end
    end

    // Input sampling
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            strobe_prev_q <= 1'b0;
            in_data_q     <= 16'h0000;
        end else if (clk_en_in) begin
            strobe_prev_q <= sample_strobe_in;
            if (is_dio && in_ev) in_data_q <= digital_io_lines_in;
        end
    end

    // Output update with watchdog reset handling
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            out_lines_q    <= 16'h0000;
            killed_q       <= 1'b0;
            kill_pending_q <= 1'b0;
        end else if (clk_en_in) begin
            if (wd_exp && wd_immed) begin
                out_lines_q    <= 16'h0000;
                killed_q       <= 1'b1;
                kill_pending_q <= 1'b0;
            end else if (upd_ev) begin
                out_lines_q    <= upd_zero ? 16'h0000 : out_data_q;
                killed_q       <= upd_zero;
                kill_pending_q <= 1'b0;
            end else if (wd_exp) begin
                kill_pending_q <= 1'b1;
            end
        end
    end

    // Output strobe window and watchdog pulse counters
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stb_cnt_q <= 5'd0;
            wdp_cnt_q <= 4'd0;
        end else if (clk_en_in) begin
            if (upd_ev) stb_cnt_q <= 5'(STROBE_CYCLES);
            else if (stb_act) stb_cnt_q <= stb_cnt_q - 5'd1;
            if (core_events_in.wd_trigger) wdp_cnt_q <= 4'(WD_PULSE_CYCLES);
            else if (wdp_act) wdp_cnt_q <= wdp_cnt_q - 4'd1;
        end
    end

    // Digital line pins, strobe, watchdog pulse and read data
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            digital_io_lines_out    <= 16'h0000;
            digital_io_lines_oe_out <= 16'h0000;
            output_strobe_out       <= 1'b0;
            watchdog_pulse_out      <= 1'b0;
            reg_rdata_out           <= 32'h0000_0000;
        end else if (clk_en_in) begin
            digital_io_lines_out    <= external_output_kill_in ? 16'h0000 : out_lines_q;
            digital_io_lines_oe_out <= oe_next;
            output_strobe_out       <= stb_level;
            watchdog_pulse_out      <= wdp_act;
            reg_rdata_out           <= reg_req_in.rd ? rd_mux : 32'h0000_0000;
        end
    end

    // Checks
    a_stamp_rise_time: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        clk_en_in && latch_rise[0] |=> stamp_q[0] == $past(system_time_in))
        else $error("rising stamp a missed system time");
    a_stamp_fall_time: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        clk_en_in && latch_fall[1] |=> stamp_q[3] == $past(system_time_in))
        else $error("falling stamp b missed system time");
    a_latch_held_low: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        clk_en_in && sync_sel[0] |=> !latch_prev_q[0])
        else $error("edge input a not held low behind output");
    a_pin_input_mode: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        clk_en_in && !sync_sel[1] |=> !shared_pin_b_oe_out)
        else $error("pin b driven while in input mode");
    a_sync_pulse_len: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        clk_en_in && sync_start[0] && pulse_len_q == 16'h0003 |=> sync_act[0] [*3] ##1
        (!sync_act[0] || $past(sync_start[0])))
        else $error("time event a pulse length wrong");
    a_event_map_state: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        clk_en_in && sync_map[1] && sync_act[1] |=> event_req_state_out[1])
        else $error("mapped state b not reflected");
    a_wd_immed_zero: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        clk_en_in && wd_exp && wd_immed |=> out_lines_q == 16'h0000 && killed_q)
        else $error("immediate watchdog reset not applied");
    a_wd_stays_zero: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        clk_en_in && upd_ev && killed_q && !fresh_q && !data_wr |=> out_lines_q == 16'h0000)
        else $error("outputs left zero state without new data");
    a_wd_pulse_out: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        clk_en_in && core_events_in.wd_trigger ##1 clk_en_in |=> watchdog_pulse_out)
        else $error("watchdog pulse not emitted");
    a_kill_lines_zero: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        clk_en_in && external_output_kill_in |=> digital_io_lines_out == 16'h0000)
        else $error("kill input did not zero lines");
    a_pair_direction: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        clk_en_in && is_dio && !port_cfg_q[PCFG_BIDIR] |=>
        digital_io_lines_oe_out[1:0] == {2{$past(ext_cfg_q[0])}})
        else $error("pair 0 direction mismatch");
    a_stamp_fall_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        clk_en_in && latch_fall[0] |=> stamp_q[1] == $past(system_time_in))
        else $error("falling stamp a missed system time");
    a_pin_level: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        clk_en_in && sync_sel[0] |=>
        shared_pin_a_out == ($past(sync_act[0]) ^ $past(sync_pol[0])))
        else $error("pin a level ignores polarity");
    a_event_map_off: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        clk_en_in && !sync_map[0] |=> !event_req_state_out[0])
        else $error("unmapped state a reflected");
    a_strobe_wd_map: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        clk_en_in && port_cfg_q[PCFG_STB_WD_MAP] && wdp_act && !port_cfg_q[PCFG_STB_POL] |=>
        output_strobe_out)
        else $error("watchdog pulse missing on strobe");
    a_strobe_window: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        clk_en_in && upd_ev && !port_cfg_q[PCFG_STB_POL] ##1 clk_en_in |=> output_strobe_out)
        else $error("strobe not active after update");
    a_update_applies: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        clk_en_in && upd_ev && !upd_zero && !(wd_exp && wd_immed) |=>
        out_lines_q == $past(out_data_q))
        else $error("update did not apply output data");
    a_input_sample: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        clk_en_in && is_dio && in_ev |=> in_data_q == $past(digital_io_lines_in))
        else $error("input data not sampled at event");
    a_non_dio_quiet: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        clk_en_in && !is_dio |=> digital_io_lines_oe_out == 16'h0000)
        else $error("lines driven outside digital mode");

endmodule : digital_io_process_port_sync_latch

// ===== tb/dio_partner.sv
`timescale 1ns/1ps
// Simple external input device and the pulled-up shared pin a
module dio_partner (
    input  wire logic [15:0] lines_out_in,
    input  wire logic [15:0] lines_oe_in,
    input  wire logic [15:0] pattern_in,
    input  wire logic        pin_a_out_in,
    input  wire logic        pin_a_oe_in,
    output logic [15:0]      lines_in_out,
    output logic             pin_a_out
);
    // Driven lines read back, released lines show the device pattern
    assign lines_in_out = (lines_oe_in & lines_out_in) | (~lines_oe_in & pattern_in);
    // Released shared pin goes to its pull-up
    assign pin_a_out = pin_a_oe_in ? pin_a_out_in : 1'b1;
endmodule : dio_partner

// ===== tb/digital_io_process_port_sync_latch_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module digital_io_process_port_sync_latch_tb;
    import dio_port_pkg::*;
    logic clk_sys_in = 0, arst_n_in = 0, pin_a, kill = 0, en = 1, pa_o, pa_oe, strobe, wdp;
    reg_req_t     rq = '0;
    eeprom_load_t ee = '0;
    core_events_t ev = '0;
    logic [31:0]  rdata, v;
    logic [15:0]  lo, loe, li, pat = 16'h3c5a;
    logic [1:0]   evs;
    logic [63:0]  tnow = '0, t0;
    int           n_fail = 0, num_checks = 0, cyc = 0;
    digital_io_process_port_sync_latch DUT (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
        .clk_en_in(en), .reg_req_in(rq), .reg_rdata_out(rdata), .eeprom_load_in(ee),
        .core_events_in(ev), .system_time_in(tnow), .shared_pin_a_in(pin_a),
        .shared_pin_a_out(pa_o), .shared_pin_a_oe_out(pa_oe), .shared_pin_b_in(pin_a),
        .shared_pin_b_out(), .shared_pin_b_oe_out(), .edge_stamp_alt_b_in(1'b0),
        .sample_strobe_in(1'b0), .external_output_kill_in(kill), .digital_io_lines_in(li),
        .digital_io_lines_out(lo), .digital_io_lines_oe_out(loe),
        .output_strobe_out(strobe), .watchdog_pulse_out(wdp), .event_req_state_out(evs));
    dio_partner PEER (.lines_out_in(lo), .lines_oe_in(loe), .pattern_in(pat),
        .pin_a_out_in(pa_o), .pin_a_oe_in(pa_oe), .lines_in_out(li), .pin_a_out(pin_a));
    // Clock, free-running time base and hang guard
    initial forever #2.5 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        tnow <= tnow + 64'h1;
        if (++cyc == 20000) begin n_fail++; print_verdict(); end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in) rq <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys_in) rq <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_in) rq <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clk_sys_in) rq <= '0;
        #1 d = rdata;
    endtask : rd
    task automatic pulse(input core_events_t e);
        @(posedge clk_sys_in) ev <= e;
        @(posedge clk_sys_in) ev <= '0;
    endtask : pulse
    // Pairs all out, update at frame end, then kill and watchdog zero the lines
    task automatic t_outputs;
        wr(OFF_EXT_CFG, 32'hff); wr(OFF_OUT_DATA, 32'ha5c3);
        pulse(7'h20); @(posedge clk_sys_in) #1;
        `CHK("lines", 16'ha5c3, lo)
        `CHK("oe", 16'hffff, loe)
        `CHK("stb", 1'b1, strobe)
        @(posedge clk_sys_in) {kill, en} <= 2'b10;
        @(posedge clk_sys_in) #1 `CHK("freeze", 16'ha5c3, lo)
        @(posedge clk_sys_in) en <= 1;
        @(posedge clk_sys_in) #1 `CHK("kill", 16'h0000, lo)
        @(posedge clk_sys_in) kill <= 0;
        wr(OFF_PORT_CFG, 32'h60); pulse(7'h08); @(posedge clk_sys_in) #1;
        `CHK("wd", 16'h0000, lo)
        pulse(7'h20); @(posedge clk_sys_in) #1;
        `CHK("wd hold", 16'h0000, lo)
        wr(OFF_OUT_DATA, 32'h0ff0); pulse(7'h24); @(posedge clk_sys_in) #1;
        `CHK("new data", 16'h0ff0, lo)
        `CHK("wd pulse", 1'b1, wdp)
    endtask : t_outputs
    // Upper four pairs as inputs, sample at frame start, unmapped address reads zero
    task automatic t_inputs;
        wr(OFF_EXT_CFG, 32'h0f); pulse(7'h40); rd(OFF_IN_DATA, v);
        `CHK("in", 16'h3cf0, v[15:0])
        `CHK("loe", 16'h00ff, loe)
        rd(8'h40, v); `CHK("unmapped", 32'h0, v)
    endtask : t_inputs
    // Pin a as open-drain time event mapped to state, length from EEPROM
    task automatic t_time_event;
        @(posedge clk_sys_in) ee <= '{1'b1, OFF_PULSE_LEN, 16'h0003};
        @(posedge clk_sys_in) ee <= '0;
        wr(OFF_SYNC_CFG, 32'h8f); pulse(7'h03); @(posedge clk_sys_in) #1;
        `CHK("pin oe", 1'b1, pa_oe)
        `CHK("pin lvl", 1'b0, pa_o)
        `CHK("state", 2'b11, evs)
        repeat (3) @(posedge clk_sys_in); #1;
        `CHK("pin end", 1'b0, pa_oe)
        wr(OFF_SYNC_CFG, 32'h00); @(posedge clk_sys_in) t0 = tnow;
        rd(OFF_STAMP_BASE, v); `CHK("stamp", t0[31:0], v)
    endtask : t_time_event
    // One port-select code per kind lands in its one-hot kind
    task automatic t_codes;
        logic [7:0] c [8] = '{8'h00, 8'h04, 8'h05, 8'h80, 8'h8c, 8'h8d, 8'h94, 8'h95};
        for (int i = 0; i < 8; i++) begin
            wr(OFF_PORT_SELECT, {24'h0, c[i]}); rd(OFF_EVENT_REQ, v);
            `CHK("kind", 8'h01 << i, v[15:8])
        end
    endtask : t_codes
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (2) @(posedge clk_sys_in);
        arst_n_in <= 1;
        rd(OFF_PORT_SELECT, v); `CHK("sel rst", 32'h04, v)
        t_outputs(); t_inputs(); t_time_event(); t_codes();
        print_verdict();
    end
endmodule : digital_io_process_port_sync_latch_tb
